/* File: common/pfp_pkg.sv */
// constants and types for the protection fault priority controller
// assumes one 100 MHz clock and comparator inputs synchronous to it
package pfp_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_DIV      = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W         = 16;
  localparam logic [CNT_W-1:0] DLY_OC_DET  = 16'h03E8;
  localparam logic [CNT_W-1:0] DLY_OC_REL  = 16'h0064;
  localparam logic [CNT_W-1:0] DLY_OD_DET  = 16'h0064;
  localparam logic [CNT_W-1:0] DLY_OD_REL  = 16'h0010;
  localparam logic [CNT_W-1:0] DLY_OI_DET  = 16'h000A;
  localparam logic [CNT_W-1:0] DLY_OI_REL  = 16'h0010;
  localparam logic [CNT_W-1:0] DLY_XC_DET  = 16'h0064;
  localparam logic [CNT_W-1:0] DLY_XC_REL  = 16'h0010;
  localparam logic [CNT_W-1:0] DLY_SC_CLK  = 16'h0032;
  localparam logic [CNT_W-1:0] DLY_SHORT   = 16'h0001;
  typedef enum logic [1:0] {PFP_TERM_OPEN, PFP_TERM_PDN, PFP_TERM_PUP}
    pfp_term_t;
  function automatic logic [CNT_W-1:0] pfp_dly(
    input logic [CNT_W-1:0] nominal,
    input logic             shorten
  );
    pfp_dly = shorten ? DLY_SHORT : nominal;
  endfunction
endpackage

/* File: rtl/pfp_tick.sv */
// divider giving the delay counter tick enable
// assumes sys_clk at the package rate
`timescale 1ns/10ps
module pfp_tick
  import pfp_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    if (rst || cnt_q == 16'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign tick = (cnt_q == 16'(DIV - 1)) && !rst;
endmodule // pfp_tick

/* File: rtl/pfp_timer.sv */
// one detect/release delay timer advancing on an enable
// assumes cond is synchronous and limit is at least one
`timescale 1ns/10ps
module pfp_timer
  import pfp_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_q;

  // a dropped run clears the count: detection restarts from zero
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt_q <= '0;
    end else if (en && cnt_q < limit) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign done = run && (cnt_q >= limit);
endmodule // pfp_timer

/* File: rtl/pfp_ctrl.sv */
// overlap priority controller for a two-cell protection device
// assumes comparator levels are already synchronous to sys_clk
`timescale 1ns/10ps
module pfp_ctrl
  import pfp_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rst,
  input  wire logic  cmp_ovchg,
  input  wire logic  cmp_ovchg_rel,
  input  wire logic  cmp_ovdis,
  input  wire logic  cmp_ovcur,
  input  wire logic  cmp_short,
  input  wire logic  cmp_xchg,
  input  wire logic  cmp_stby_rel,
  input  wire logic  shorten,
  output logic       chg_en,
  output logic       dis_en,
  output pfp_term_t  sense_term,
  output logic       standby,
  output logic       st_ovchg,
  output logic       st_ovdis,
  output logic       st_ovcur,
  output logic       st_short,
  output logic       st_xchg
);
  logic             tick;
  logic             oc_q;
  logic             od_q;
  logic             oi_q;
  logic             sc_q;
  logic             xc_q;
  logic             oi_first_q;
  logic             stby_q;
  logic             chg_en_q;
  logic             dis_en_q;
  pfp_term_t        term_q;
  // timer run and done pairs, detect then release
  logic             oc_run;
  logic             oc_det;
  logic             ocr_run;
  logic             ocr_det;
  logic             od_run;
  logic             od_det;
  logic             odr_run;
  logic             odr_det;
  logic             oi_run;
  logic             oi_det;
  logic             oir_run;
  logic             oir_det;
  logic             sc_run;
  logic             sc_det;
  logic             xc_run;
  logic             xc_det;
  logic             xcr_run;
  logic             xcr_det;
  logic             oc_pend;
  logic             dis_fault;
  // delay limits, chosen once per timer from the shorten pin
  logic [CNT_W-1:0] lim_oc;
  logic [CNT_W-1:0] lim_ocr;
  logic [CNT_W-1:0] lim_od;
  logic [CNT_W-1:0] lim_odr;
  logic [CNT_W-1:0] lim_oi;
  logic [CNT_W-1:0] lim_oir;
  logic [CNT_W-1:0] lim_xc;
  logic [CNT_W-1:0] lim_xcr;

  pfp_tick u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick)
  );

  // over-charge timing always runs, also during over-current
  assign oc_run  = cmp_ovchg && !oc_q;
  assign oc_pend = oc_run;
  assign ocr_run = oc_q && cmp_ovchg_rel;
  // over-discharge timing waits while over-charge is being timed
  // not gated by over-current: both are timed side by side
  assign od_run  = cmp_ovdis && !od_q && !stby_q && !oc_pend;
  assign odr_run = od_q && !cmp_ovdis && !stby_q;
  // over-current is timed alongside, dropped once a winner is in
  assign oi_run  = cmp_ovcur && !oi_q && !oc_q && !od_q;
  // short shares this release; without it a short flag would never clear
  assign oir_run = (oi_q || sc_q) && !cmp_ovcur;
  // short-circuit uses the system clock, not the shortenable tick
  assign sc_run  = cmp_short && !sc_q;
  assign dis_fault = od_q || oi_q || sc_q;
  // charger check only with discharge output back high
  assign xc_run  = cmp_xchg && !xc_q && !dis_fault && dis_en_q;
  assign xcr_run = xc_q && !cmp_xchg;

  // counter delays only; the short delay never sees the shorten pin
  assign lim_oc  = pfp_dly(DLY_OC_DET, shorten);
  assign lim_ocr = pfp_dly(DLY_OC_REL, shorten);
  assign lim_od  = pfp_dly(DLY_OD_DET, shorten);
  assign lim_odr = pfp_dly(DLY_OD_REL, shorten);
  assign lim_oi  = pfp_dly(DLY_OI_DET, shorten);
  assign lim_oir = pfp_dly(DLY_OI_REL, shorten);
  assign lim_xc  = pfp_dly(DLY_XC_DET, shorten);
  assign lim_xcr = pfp_dly(DLY_XC_REL, shorten);

  // every timer restarts from zero when its condition drops
  pfp_timer u_oc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (tick),
    .run     (oc_run),
    .limit   (lim_oc),
    .done    (oc_det)
  );

  pfp_timer u_ocr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (tick),
    .run     (ocr_run),
    .limit   (lim_ocr),
    .done    (ocr_det)
  );

  pfp_timer u_od (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (tick),
    .run     (od_run),
    .limit   (lim_od),
    .done    (od_det)
  );

  pfp_timer u_odr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (tick),
    .run     (odr_run),
    .limit   (lim_odr),
    .done    (odr_det)
  );

  pfp_timer u_oi (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (tick),
    .run     (oi_run),
    .limit   (lim_oi),
    .done    (oi_det)
  );

  pfp_timer u_oir (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (tick),
    .run     (oir_run),
    .limit   (lim_oir),
    .done    (oir_det)
  );

  // runs on every clock, so it stays far shorter than over-current
  pfp_timer u_sc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (1'b1),
    .run     (sc_run),
    .limit   (DLY_SC_CLK),
    .done    (sc_det)
  );

  // charger detect and release share the tick like the others
  pfp_timer u_xc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (tick),
    .run     (xc_run),
    .limit   (lim_xc),
    .done    (xc_det)
  );

  pfp_timer u_xcr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (tick),
    .run     (xcr_run),
    .limit   (lim_xcr),
    .done    (xcr_det)
  );

  // over-charge, over-discharge, over-current and charger flags move only on the counter tick
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oc_q <= 1'b0;
    end else if (tick) begin
      if (oc_det) begin
        oc_q <= 1'b1;
      end else if (ocr_det) begin
        oc_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      od_q <= 1'b0;
    end else if (tick) begin
      if (od_det) begin
        od_q <= 1'b1;
      end else if (odr_det || (stby_q && cmp_stby_rel && !cmp_ovdis)) begin
        od_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oi_q       <= 1'b0;
      oi_first_q <= 1'b0;
    end else if (tick) begin
      if (oi_det) begin
        oi_q       <= 1'b1;
        oi_first_q <= !oc_q && !od_q;
      end else if (oir_det) begin
        oi_q       <= 1'b0;
        oi_first_q <= 1'b0;
      end
    end
  end

  // short flag follows the system-clock timer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sc_q <= 1'b0;
    end else if (sc_det) begin
      sc_q <= 1'b1;
    end else if (tick && oir_det) begin
      sc_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xc_q <= 1'b0;
    end else if (tick) begin
      if (xc_det) begin
        xc_q <= 1'b1;
      end else if (xcr_det) begin
        xc_q <= 1'b0;
      end
    end
  end

  // stand-by only when over-discharge is not behind over-charge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stby_q <= 1'b0;
    end else if (tick && od_det && !oc_q) begin
      stby_q <= 1'b1;
    end else if (tick && od_det && oc_q) begin
      stby_q <= 1'b0;
    end else if (cmp_stby_rel || !od_q) begin
      stby_q <= 1'b0;
    end
  end

  // sense node termination, pull-up beats pull-down
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      term_q <= PFP_TERM_OPEN;
    end else if (od_q) begin
      term_q <= PFP_TERM_PUP;
    end else if ((oi_q && oi_first_q) || sc_q) begin
      term_q <= PFP_TERM_PDN;
    end else begin
      term_q <= PFP_TERM_OPEN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chg_en_q <= 1'b1;
    end else begin
      chg_en_q <= !(oc_q || xc_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dis_en_q <= 1'b1;
    end else begin
      dis_en_q <= !dis_fault;
    end
  end

  assign chg_en     = chg_en_q;
  assign dis_en     = dis_en_q;
  assign sense_term = term_q;
  assign standby    = stby_q;
  assign st_ovchg   = oc_q;
  assign st_ovdis   = od_q;
  assign st_ovcur   = oi_q;
  assign st_short   = sc_q;
  assign st_xchg    = xc_q;
endmodule // pfp_ctrl

/* File: verification/pfp_ctrl_assertions.sv */
// port checker for pfp_ctrl
// bound from the bench top; one clock, sync reset
`timescale 1ns/10ps
module pfp_ctrl_chk
  import pfp_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      rst,
  input wire logic      cmp_short,
  input wire logic      chg_en,
  input wire logic      dis_en,
  input wire pfp_term_t sense_term,
  input wire logic      standby,
  input wire logic      st_ovchg,
  input wire logic      st_ovdis,
  input wire logic      st_ovcur,
  input wire logic      st_short,
  input wire logic      st_xchg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic  dfault = st_ovdis | st_ovcur | st_short;
  logic [7:0] dis_hi_q;
  // saturates so a long quiet run cannot wrap
  always_ff @(posedge sys_clk) begin
    if (rst || !dis_en) dis_hi_q <= 8'h00;
    else if (dis_hi_q != 8'hFF) dis_hi_q <= dis_hi_q + 8'h01;
  end
  sequence s_short_up;
    $rose(cmp_short);
  endsequence
  sequence s_oc_up;
    $rose(st_ovcur);
  endsequence
  chk_dis_low: assert property (dfault |=> !dis_en)
    else $error("discharge stays on during fault");
  chk_chg_low: assert property ((st_ovchg | st_xchg) |=> !chg_en)
    else $error("charge stays on during fault");
  chk_pull_up: assert property (st_ovdis |=> sense_term == PFP_TERM_PUP)
    else $error("no pull-up after over-discharge");
  chk_pull_down: assert property
    (st_ovcur && !st_ovdis && !st_ovchg |=> sense_term == PFP_TERM_PDN)
    else $error("no pull-down after over-current");
  chk_sense_open: assert property
    (st_ovchg && !dfault |=> sense_term == PFP_TERM_OPEN)
    else $error("sense not released");
  chk_stby_entry: assert property
    ($rose(standby) |-> st_ovdis && !$past(st_ovchg))
    else $error("wrong stand-by entry");
  chk_oc_abort: assert property
    (s_oc_up |-> !$past(st_ovchg) && !$past(st_ovdis))
    else $error("over-current not aborted");
  chk_xchg_gate: assert property
    ($rose(st_xchg) |-> !$past(dfault) && dis_hi_q >= 8'h64)
    else $error("charger detect while discharge off");
  chk_short_time: assert property
    (s_short_up |-> ##[1:60] (st_short || !cmp_short))
    else $error("short not detected in time");
endmodule // pfp_ctrl_chk

/* File: verification/protection_fault_priority_ctrl_tb_top.sv */
// bench for pfp_ctrl overlap priorities
// assumes pfp_pkg delays; inputs change 1 ns after the edge
`timescale 1ns/10ps
module protection_fault_priority_ctrl_tb_top;
  import pfp_pkg::*;
  logic      sys_clk = 1'b0;
  logic      rst = 1'b1;
  logic      cmp_ovchg, cmp_ovchg_rel, cmp_ovdis, cmp_ovcur, cmp_short;
  logic      cmp_xchg, cmp_stby_rel, shorten;
  logic      chg_en, dis_en, standby;
  pfp_term_t sense_term;
  logic      st_ovchg, st_ovdis, st_ovcur, st_short, st_xchg;
  int        fails = 0;
  int        n_checks = 0;
  wire logic [4:0] st = {st_xchg, st_short, st_ovcur, st_ovdis, st_ovchg};
  pfp_ctrl u_dut (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .cmp_ovchg     (cmp_ovchg),
    .cmp_ovchg_rel (cmp_ovchg_rel),
    .cmp_ovdis     (cmp_ovdis),
    .cmp_ovcur     (cmp_ovcur),
    .cmp_short     (cmp_short),
    .cmp_xchg      (cmp_xchg),
    .cmp_stby_rel  (cmp_stby_rel),
    .shorten       (shorten),
    .chg_en        (chg_en),
    .dis_en        (dis_en),
    .sense_term    (sense_term),
    .standby       (standby),
    .st_ovchg      (st_ovchg),
    .st_ovdis      (st_ovdis),
    .st_ovcur      (st_ovcur),
    .st_short      (st_short),
    .st_xchg       (st_xchg)
  );
  initial forever #5 sys_clk = ~sys_clk;
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] exp,
                       input string msg);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic do_reset;
    {cmp_ovchg, cmp_ovchg_rel, cmp_ovdis, cmp_ovcur} = 4'h0;
    {cmp_short, cmp_xchg, cmp_stby_rel} = 3'h0;
    shorten = 1'b1;
    rst = 1'b1;
    step(20);
    rst = 1'b0;
  endtask
  // bounded so a missing flag cannot hang the run
  task automatic wait_st(input int i, output int k);
    k = 0;
    while (st[i] !== 1'b1 && k < 400) begin
      step(1);
      k++;
    end
  endtask
  task automatic t_ovcur_first;
    int k;
    do_reset();
    check({chg_en, dis_en, standby}, 3'h6, "reset outputs");
    cmp_ovcur = 1'b1;
    wait_st(2, k);
    step(2);
    check({st_ovcur, dis_en}, 2'h2, "over-current off");
    check(sense_term, PFP_TERM_PDN, "pull-down");
    cmp_ovdis = 1'b1;
    wait_st(1, k);
    check(st_ovdis, 1'b1, "over-discharge blocked");
    step(2);
    check({sense_term, standby}, {PFP_TERM_PUP, 1'b1}, "stand-by");
  endtask
  task automatic t_ovchg_first;
    int k;
    do_reset();
    {cmp_ovchg, cmp_ovdis} = 2'h3;
    wait_st(0, k);
    check(st_ovdis, 1'b0, "over-discharge first");
    step(2);
    check({chg_en, sense_term}, {1'b0, PFP_TERM_OPEN}, "open");
    cmp_ovcur = 1'b1;
    wait_st(1, k);
    check(st_ovdis, 1'b1, "no resume");
    step(2);
    check({sense_term, standby}, {PFP_TERM_PUP, 1'b0}, "stand-by");
    step(300);
    check(st_ovcur, 1'b0, "over-current kept");
  endtask
  task automatic t_ovdis_first;
    int k;
    do_reset();
    cmp_ovdis = 1'b1;
    wait_st(1, k);
    step(2);
    check({sense_term, standby, dis_en}, 4'hA, "pull-up");
    {cmp_ovcur, cmp_xchg} = 2'h3;
    step(400);
    check({st_ovcur, st_xchg}, 2'h0, "not inhibited");
  endtask
  task automatic t_xchg;
    int k;
    do_reset();
    cmp_xchg = 1'b1;
    wait_st(4, k);
    step(2);
    check({st_xchg, chg_en}, 2'h2, "charger");
  endtask
  task automatic t_short;
    int k;
    do_reset();
    shorten = 1'b0;
    {cmp_short, cmp_ovcur} = 2'h3;
    wait_st(3, k);
    check(k >= 48 && k <= 54, 1'b1, "short delay");
    step(2);
    check({dis_en, sense_term}, {1'b0, PFP_TERM_PDN}, "short off");
    step(300);
    check(st_ovcur, 1'b0, "delay not normal");
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    t_ovcur_first();
    t_ovchg_first();
    t_ovdis_first();
    t_xchg();
    t_short();
    report_and_stop();
  end
  initial begin
    #300_000;
    fails++;
    report_and_stop();
  end
endmodule // protection_fault_priority_ctrl_tb_top
bind pfp_ctrl pfp_ctrl_chk u_chk (
  .sys_clk    (sys_clk),
  .rst        (rst),
  .cmp_short  (cmp_short),
  .chg_en     (chg_en),
  .dis_en     (dis_en),
  .sense_term (sense_term),
  .standby    (standby),
  .st_ovchg   (st_ovchg),
  .st_ovdis   (st_ovdis),
  .st_ovcur   (st_ovcur),
  .st_short   (st_short),
  .st_xchg    (st_xchg)
);
